// >>> dv/bfc_sync_src.sv
// external sync clock source feeding the sync pin
`timescale 1ns/10ps
`default_nettype none
module bfc_sync_src
(
    // control from the bench
    input wire logic run,
    input wire logic level,
    input wire logic [15:0] half_ns,
    // sync pin
    output logic boost_sync_pin
);
    // toggles while running, else rests at the static level
    initial
    begin
        boost_sync_pin = 1'b0;
        #2;
        forever
        begin
            #(run ? half_ns : 16'ha);
            boost_sync_pin = run ? ~boost_sync_pin : level;
        end
    end
endmodule
`default_nettype wire

// >>> dv/bfc_top_asserts.sv
// port assertions for the boost fault and clock-mode block
`timescale 1ns/10ps
`default_nettype none
module bfc_top_asserts
#(
    parameter UV_CYCLES = 200,
    parameter LOST_CYCLES = 1100
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // comparators and sync pin
    input wire logic ovl_cmp,
    input wire logic ovh_cmp,
    input wire logic uv_cmp,
    input wire logic boost_sync_pin,
    // boost stage
    input wire logic boost_gate,
    input wire logic fault_recovery,
    input wire logic ext_sync_mode,
    input wire logic spread_active,
    input wire logic pulse_skip_mode
);
    logic [31:0] uv_cnt;
    logic [31:0] idle_cnt;
    logic pin_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // steady undervoltage cycles and cycles since the pin last moved
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            uv_cnt <= 32'h0;
            idle_cnt <= 32'h0;
            pin_q <= 1'b0;
        end
        else
        begin
            uv_cnt <= uv_cmp ? uv_cnt + 32'h1 : 32'h0;
            idle_cnt <= (boost_sync_pin != pin_q) ? 32'h0 : idle_cnt + 32'h1;
            pin_q <= boost_sync_pin;
        end
    end
    a_ovl_gate_off: assert property (
        ovl_cmp [*5] |-> !boost_gate) else $error("gate on in overvoltage");
    a_ovh_recover: assert property (
        ovh_cmp [*5] |-> fault_recovery) else $error("no fault recovery");
    a_recover_gate: assert property (
        fault_recovery [*3] |-> !boost_gate) else $error("gate in recovery");
    a_uv_timeout: assert property (
        uv_cnt == UV_CYCLES + 5 |-> fault_recovery) else $error("no uv timeout");
    a_ext_no_spread: assert property (
        ext_sync_mode && $past(ext_sync_mode) |-> !spread_active)
        else $error("spread on in external mode");
    a_lost_sync: assert property (
        idle_cnt == LOST_CYCLES + 5 |-> !ext_sync_mode)
        else $error("sync clock not dropped");
    a_pin_spread: assert property (
        idle_cnt == LOST_CYCLES + 6 |-> spread_active == boost_sync_pin)
        else $error("spread differs from pin");
    a_setup_answer: assert property (
        psel && !penable |=> pready) else $error("no ready after setup");
    a_ready_pulse: assert property (
        pready |=> !pready) else $error("ready longer than one cycle");
    cover property ($rose(ext_sync_mode));
    cover property ($rose(fault_recovery));
    cover property ($rose(pulse_skip_mode));
endmodule
bind bfc_top bfc_top_asserts #(.UV_CYCLES(UV_CYCLES),
    .LOST_CYCLES(LOST_CYCLES)) u_chk (.pclk, .presetn, .psel, .penable,
    .pready, .ovl_cmp, .ovh_cmp, .uv_cmp, .boost_sync_pin, .boost_gate,
    .fault_recovery, .ext_sync_mode, .spread_active, .pulse_skip_mode);
`default_nettype wire

// >>> dv/bfc_top_tb_top.sv
// bench for the boost fault and clock-mode block
`timescale 1ns/10ps
`default_nettype none
module bfc_top_tb_top;
    localparam UV = 200;
    localparam LOST = 1100;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic ovl = 1'b0, ovh = 1'b0, uv = 1'b0, ll = 1'b0;
    logic run = 1'b0, lvl = 1'b0, err, seen;
    logic [15:0] half = 16'h0;
    logic [31:0] q;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, pin, gate, frec, ext, spr, psk, irq;
    int num_errors = 0;
    int checks = 0;
    int n_ll, n_nm;
    // 100 MHz clock
    always #5 pclk = ~pclk;
    bfc_sync_src i_src (.run, .level(lvl), .half_ns(half),
        .boost_sync_pin(pin));
    bfc_top #(.UV_CYCLES(UV), .LOST_CYCLES(LOST)) i_dut (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .ovl_cmp(ovl), .ovh_cmp(ovh), .uv_cmp(uv),
        .light_load(ll), .boost_sync_pin(pin), .boost_gate(gate),
        .fault_recovery(frec), .ext_sync_mode(ext), .spread_active(spr),
        .pulse_skip_mode(psk), .irq);
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    // one apb transfer launched on an edge, read data taken with pready
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (n == 20)
            num_errors++;
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // watchdog
    initial
    begin
        #500000;
        num_errors++;
        final_report();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        cyc(3);
        rc(12'h004, 32'h0);
        rc(12'h008, 32'h2);
        rc(12'h00c, 32'h1);
        rc(12'h010, 32'hfa);
        rc(12'h020, 32'h0);
        chkb(err, 1'b1);
        chkb(ext, 1'b0);
        for (int i = 0; i < 16; i++)
        begin
            apb(1'b1, 12'h008, 32'(i));
            rc(12'h008, 32'(i));
        end
        done("registers");
        apb(1'b1, 12'h004, 32'h7);
        ovl <= 1'b1;
        cyc(600);
        chkb(gate, 1'b0);
        chkb(irq, 1'b1);
        ovl <= 1'b0;
        seen = 1'b0;
        repeat (600)
        begin
            cyc(1);
            seen = seen | gate;
        end
        chkb(seen, 1'b1);
        rc(12'h000, 32'h1);
        apb(1'b1, 12'h000, 32'h1);
        cyc(2);
        chkb(irq, 1'b0);
        done("overvoltage low");
        // boost enable off keeps the switch still
        apb(1'b1, 12'h00c, 32'h0);
        cyc(2);
        seen = 1'b0;
        repeat (300)
        begin
            cyc(1);
            seen = seen | gate;
        end
        chkb(seen, 1'b0);
        apb(1'b1, 12'h00c, 32'h1);
        uv <= 1'b1;
        cyc(UV / 2);
        uv <= 1'b0;
        cyc(10);
        chkb(frec, 1'b0);
        uv <= 1'b1;
        cyc(UV + 20);
        chkb(frec, 1'b1);
        uv <= 1'b0;
        rc(12'h000, 32'h4);
        apb(1'b1, 12'h000, 32'h4);
        apb(1'b1, 12'h00c, 32'h3);
        apb(1'b1, 12'h004, 32'h0);
        ovh <= 1'b1;
        cyc(10);
        ovh <= 1'b0;
        cyc(5);
        chkb(frec, 1'b1);
        chkb(irq, 1'b0);
        rc(12'h000, 32'h2);
        apb(1'b1, 12'h000, 32'h2);
        apb(1'b1, 12'h00c, 32'h3);
        cyc(2);
        chkb(frec, 1'b0);
        done("faults");
        // gate-on cycles over two periods, skipping then normal
        ll <= 1'b1;
        cyc(100);
        n_ll = 0;
        repeat (500)
        begin
            cyc(1);
            n_ll += gate;
        end
        chkb(psk, 1'b1);
        ll <= 1'b0;
        cyc(100);
        n_nm = 0;
        repeat (500)
        begin
            cyc(1);
            n_nm += gate;
        end
        chkb(psk, 1'b0);
        chkb(n_ll < n_nm, 1'b1);
        lvl <= 1'b1;
        cyc(20);
        chkb(spr, 1'b1);
        lvl <= 1'b0;
        cyc(20);
        chkb(spr, 1'b0);
        // both rates match a resistor setting
        for (int j = 0; j < 2; j++)
        begin
            apb(1'b1, 12'h010, j ? 32'h3e8 : 32'h2d);
            half <= j ? 16'h1388 : 16'h00e1;
            run <= 1'b1;
            cyc(j ? 8000 : 1200);
            chkb(ext, 1'b1);
            chkb(spr, 1'b0);
            lvl <= 1'b1;
            run <= 1'b0;
            cyc(LOST + 600);
            chkb(ext, 1'b0);
            chkb(spr, 1'b1);
            lvl <= 1'b0;
            cyc(20);
        end
        done("sync");
        final_report();
    end
endmodule
`default_nettype wire

// >>> rtl/bfc_map.vh
// constants and register map of the boost fault and clock-mode block
// Contract
// R1: an overvoltage-low trip stops the switch and sets its flag; sinks stay on.
// R2: an overvoltage-high trip enters fault recovery and sets its flag.
// R3: reaching the undervoltage level starts a 110 ms timer.
// R4: undervoltage still present at timer expiry enters fault recovery with a flag.
// R5: a static sync pin level enables spread spectrum when high, disables when low.
// R6: a 100 kHz to 2222 kHz sync clock drives the boost with spread disabled.
// R7: a lost sync clock falls back to the internal clock, spread set by pin level.
// R8: the board picks the frequency resistor closest to the external clock.
// R9: the span field gives 3.3, 4.3, 5.3 (default 10) or 7.2 percent deviation.
// R10: the rate field gives 200 (default 00), 500, 800 or 1200 Hz modulation.
// R11: under light load switching cycles are skipped now and then.
// R12: at start-up a sync clock is detected, else the internal clock is used.
// R13: the sync clock is lost after several slowest periods without an edge.
// R14: fault flags stay set until software clears them.
`ifndef BFC_MAP_VH
`define BFC_MAP_VH
// register byte offsets
`define BFC_STATUS_OFF 12'h000
`define BFC_MASK_OFF 12'h004
`define BFC_SPREAD_OFF 12'h008
`define BFC_CTRL_OFF 12'h00c
`define BFC_PERIOD_OFF 12'h010
`define BFC_STATE_OFF 12'h014
// status and mask bit positions
`define BFC_OVL_BIT 0
`define BFC_OVH_BIT 1
`define BFC_UVT_BIT 2
// spread config fields
`define BFC_SPAN_LSB 0
`define BFC_RATE_LSB 2
`define BFC_SPAN_RST 2'h2
`define BFC_RATE_RST 2'h0
// control fields
`define BFC_EN_BIT 0
`define BFC_RECOVER_BIT 1
`define BFC_CTRL_RST 2'h1
// switching period in pclk cycles, 400 kHz
`define BFC_PERIOD_RST 16'h00fa
// timing
`define BFC_CLK_HZ 100000000
`define BFC_UV_TIME_MS 110
`define BFC_SYNC_MIN_KHZ 100
`define BFC_SYNC_MAX_KHZ 2222
`define BFC_LOST_PERIODS 4
`define BFC_SYNC_MIN_CYC (`BFC_CLK_HZ / 1000 / `BFC_SYNC_MAX_KHZ)
`define BFC_SYNC_MAX_CYC (`BFC_CLK_HZ / 1000 / `BFC_SYNC_MIN_KHZ)
`define BFC_LOST_CYC (`BFC_SYNC_MAX_CYC * `BFC_LOST_PERIODS)
`define BFC_UV_CYC (`BFC_CLK_HZ / 1000 * `BFC_UV_TIME_MS)
// spread span factors, deviation = period * k / 1024
`define BFC_SPAN_K0 7'h22
`define BFC_SPAN_K1 7'h2c
`define BFC_SPAN_K2 7'h36
`define BFC_SPAN_K3 7'h4a
// modulation rates and ticks per triangle step (256 steps a period)
`define BFC_RATE_HZ0 200
`define BFC_RATE_HZ1 500
`define BFC_RATE_HZ2 800
`define BFC_RATE_HZ3 1200
`define BFC_TRI_STEPS 256
`define BFC_TRI_AMP 64
`endif

// >>> rtl/bfc_sync2.v
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
`default_nettype none
module bfc_sync2
#(
    parameter W = 1
)
(
    // clock and reset
    input wire pclk,
    input wire presetn,
    // levels
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);

reg [W-1:0] meta_reg;

// first stage feeds only the second
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        meta_reg <= {W{1'b0}};
        sync_out <= {W{1'b0}};
    end
    else
    begin
        meta_reg <= async_in;
        sync_out <= meta_reg;
    end
end

endmodule
`default_nettype wire

// >>> rtl/bfc_top.v
// boost fault supervision, clock-mode selection and apb registers
`timescale 1ns/10ps
`default_nettype none
`include "bfc_map.vh"
module bfc_top
#(
    parameter UV_CYCLES = `BFC_UV_CYC,
    parameter LOST_CYCLES = `BFC_LOST_CYC
)
(
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // comparators and pins
    input wire ovl_cmp,
    input wire ovh_cmp,
    input wire uv_cmp,
    input wire light_load,
    input wire boost_sync_pin,
    // boost stage
    output reg boost_gate,
    output reg fault_recovery,
    output reg ext_sync_mode,
    output reg spread_active,
    output reg pulse_skip_mode,
    // interrupt
    output reg irq
);

wire [4:0] pins_s;
reg sync_d_reg;
reg [2:0] status_reg;
reg [2:0] mask_reg;
reg [1:0] span_reg;
reg [1:0] rate_reg;
reg [1:0] ctrl_reg;
reg [15:0] period_reg;
reg [23:0] uv_cnt_reg;
reg uv_run_reg;
reg [15:0] gap_reg;
reg [15:0] meas_reg;
reg [1:0] good_reg;
reg [18:0] tick_reg;
reg [7:0] offset_reg;
reg tri_up_reg;
reg [15:0] sw_cnt_reg;
reg skip_tog_reg;
reg [31:0] rd_next;
reg map_hit;
reg [6:0] span_k;
reg [18:0] tick_max;

// integer constants, cut to the width of each use below
localparam integer SYNC_LO_I = `BFC_SYNC_MIN_CYC - 1;
localparam integer SYNC_HI_I = `BFC_SYNC_MAX_CYC - 1;
localparam integer TRI_AMP_I = `BFC_TRI_AMP;
localparam integer TICK0_I = `BFC_CLK_HZ / `BFC_RATE_HZ0 / `BFC_TRI_STEPS;
localparam integer TICK1_I = `BFC_CLK_HZ / `BFC_RATE_HZ1 / `BFC_TRI_STEPS;
localparam integer TICK2_I = `BFC_CLK_HZ / `BFC_RATE_HZ2 / `BFC_TRI_STEPS;
localparam integer TICK3_I = `BFC_CLK_HZ / `BFC_RATE_HZ3 / `BFC_TRI_STEPS;

wire ovl_s = pins_s[0];
wire ovh_s = pins_s[1];
wire uv_s = pins_s[2];
wire load_s = pins_s[3];
wire sync_s = pins_s[4];
wire sync_rise = sync_s & ~sync_d_reg;
wire wr_acc = psel & penable & pready & pwrite & ~pslverr;
wire setup = psel & ~penable & ~pready;
wire uv_expire = uv_run_reg && (uv_cnt_reg == UV_CYCLES[23:0] - 24'h1);
wire [2:0] events = {uv_expire, ovh_s, ovl_s};
// accepted edge interval, fastest to slowest sync clock
wire gap_ok = (gap_reg >= SYNC_LO_I[15:0]) &&
    (gap_reg <= SYNC_HI_I[15:0]);
wire [22:0] dev_full = {7'h00, period_reg} * {16'h0000, span_k};
wire [12:0] dev = dev_full[22:10];
wire signed [21:0] delta_full = $signed({9'h000, dev}) *
    $signed({{14{offset_reg[7]}}, offset_reg});
wire signed [21:0] delta_sh = delta_full >>> 6;
wire [15:0] period_now = spread_active ?
    period_reg + delta_sh[15:0] : period_reg;
wire int_start = (sw_cnt_reg >= period_now - 16'h0001);
wire cycle_start = ext_sync_mode ? sync_rise : int_start;
wire [15:0] half = ext_sync_mode ? {1'b0, meas_reg[15:1]} :
    {1'b0, period_now[15:1]};
wire [15:0] phase = ext_sync_mode ? gap_reg : sw_cnt_reg;
wire blank = ovl_s | fault_recovery | ~ctrl_reg[`BFC_EN_BIT];

// comparator and pin synchroniser
bfc_sync2 #(.W(5)) u_sync
(
    .pclk(pclk),
    .presetn(presetn),
    .async_in({boost_sync_pin, light_load, uv_cmp, ovh_cmp, ovl_cmp}),
    .sync_out(pins_s)
);

// span factor and modulation tick length
always @*
begin
    case (span_reg)
        2'h0: span_k = `BFC_SPAN_K0;
        2'h1: span_k = `BFC_SPAN_K1;
        2'h2: span_k = `BFC_SPAN_K2;
        default: span_k = `BFC_SPAN_K3;
    endcase
    // R10 rate select
    case (rate_reg)
        2'h0: tick_max = TICK0_I[18:0];
        2'h1: tick_max = TICK1_I[18:0];
        2'h2: tick_max = TICK2_I[18:0];
        default: tick_max = TICK3_I[18:0];
    endcase
end

// read mux and address decode
always @*
begin
    rd_next = 32'h0000_0000;
    map_hit = 1'b1;
    case (paddr)
        `BFC_STATUS_OFF: rd_next[2:0] = status_reg;
        `BFC_MASK_OFF: rd_next[2:0] = mask_reg;
        `BFC_SPREAD_OFF: rd_next[3:0] = {rate_reg, span_reg};
        `BFC_CTRL_OFF: rd_next[1:0] = ctrl_reg;
        `BFC_PERIOD_OFF: rd_next[15:0] = period_reg;
        `BFC_STATE_OFF: rd_next[5:0] = {pulse_skip_mode, uv_run_reg,
            spread_active, ext_sync_mode, fault_recovery, boost_gate};
        default: map_hit = 1'b0;
    endcase
end

// apb handshake, no wait states
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
    end
    else if (setup)
    begin
        pready <= 1'b1;
        pslverr <= ~map_hit;
        prdata <= pwrite ? 32'h0000_0000 : rd_next;
    end
    else
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
    end
end

// configuration registers
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        mask_reg <= 3'h0;
        span_reg <= `BFC_SPAN_RST;
        rate_reg <= `BFC_RATE_RST;
        ctrl_reg <= `BFC_CTRL_RST;
        period_reg <= `BFC_PERIOD_RST;
    end
    else if (wr_acc)
    begin
        if (paddr == `BFC_MASK_OFF)
            mask_reg <= pwdata[2:0];
        // R9 span field
        if (paddr == `BFC_SPREAD_OFF)
        begin
            span_reg <= pwdata[`BFC_SPAN_LSB+1:`BFC_SPAN_LSB];
            rate_reg <= pwdata[`BFC_RATE_LSB+1:`BFC_RATE_LSB];
        end
        if (paddr == `BFC_CTRL_OFF)
            ctrl_reg <= {1'b0, pwdata[`BFC_EN_BIT]};
        if (paddr == `BFC_PERIOD_OFF)
            period_reg <= pwdata[15:0];
    end
end

// sticky status, set beats write-one clear
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        status_reg <= 3'h0;
    // R14 sticky flags
    else if (wr_acc && paddr == `BFC_STATUS_OFF)
        status_reg <= (status_reg & ~pwdata[2:0]) | events;
    else
        status_reg <= status_reg | events;
end

// undervoltage timer
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        uv_run_reg <= 1'b0;
        uv_cnt_reg <= 24'h00_0000;
    end
    // R3 timer start
    else if (!uv_s)
    begin
        uv_run_reg <= 1'b0;
        uv_cnt_reg <= 24'h00_0000;
    end
    else if (uv_expire)
        uv_run_reg <= 1'b0;
    else if (uv_run_reg)
        uv_cnt_reg <= uv_cnt_reg + 24'h00_0001;
    else if (uv_cnt_reg == 24'h00_0000)
        uv_run_reg <= 1'b1;
end

// fault recovery state
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        fault_recovery <= 1'b0;
    // R2 overvoltage-high
    // R4 undervoltage timeout
    else if (ovh_s || uv_expire)
        fault_recovery <= 1'b1;
    else if (wr_acc && paddr == `BFC_CTRL_OFF && pwdata[`BFC_RECOVER_BIT])
        fault_recovery <= 1'b0;
end

// sync edge interval measurement and lock
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        sync_d_reg <= 1'b0;
        gap_reg <= 16'h0000;
        meas_reg <= 16'h0000;
        good_reg <= 2'h0;
        ext_sync_mode <= 1'b0;
    end
    else
    begin
        sync_d_reg <= sync_s;
        if (sync_rise)
        begin
            gap_reg <= 16'h0000;
            meas_reg <= gap_reg + 16'h0001;
            // R12 detect clock
            // R6 lock in range
            if (!gap_ok)
                good_reg <= 2'h0;
            else if (good_reg != 2'h3)
                good_reg <= good_reg + 2'h1;
            if (gap_ok && good_reg == 2'h3)
                ext_sync_mode <= 1'b1;
            else if (!gap_ok)
                ext_sync_mode <= 1'b0;
        end
        // R13 loss timeout
        else if (gap_reg >= LOST_CYCLES[15:0] - 16'h0001)
        begin
            good_reg <= 2'h0;
            // R7 fall back
            ext_sync_mode <= 1'b0;
        end
        else
            gap_reg <= gap_reg + 16'h0001;
    end
end

// spread triangle modulation
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        tick_reg <= 19'h0_0000;
        offset_reg <= 8'h00;
        tri_up_reg <= 1'b1;
        spread_active <= 1'b0;
    end
    else
    begin
        // R5 pin level
        spread_active <= sync_s & ~ext_sync_mode;
        if (tick_reg >= tick_max - 19'h0_0001)
        begin
            tick_reg <= 19'h0_0000;
            // bounds compared at 8 bits so the lower one is really -64
            if (tri_up_reg && offset_reg == TRI_AMP_I[7:0])
                tri_up_reg <= 1'b0;
            else if (!tri_up_reg && offset_reg == 8'h00 - TRI_AMP_I[7:0])
                tri_up_reg <= 1'b1;
            else if (tri_up_reg)
                offset_reg <= offset_reg + 8'h01;
            else
                offset_reg <= offset_reg - 8'h01;
        end
        else
            tick_reg <= tick_reg + 19'h0_0001;
    end
end

// switching period counter and gate
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        sw_cnt_reg <= 16'h0000;
        skip_tog_reg <= 1'b0;
        pulse_skip_mode <= 1'b0;
        boost_gate <= 1'b0;
    end
    else
    begin
        if (int_start || ext_sync_mode)
            sw_cnt_reg <= 16'h0000;
        else
            sw_cnt_reg <= sw_cnt_reg + 16'h0001;
        // R11 skip alternate cycles
        if (cycle_start)
        begin
            skip_tog_reg <= load_s & ~skip_tog_reg;
            pulse_skip_mode <= load_s;
        end
        // R1 stop switching
        boost_gate <= ~blank & ~(load_s & skip_tog_reg) & (phase < half);
    end
end

// masked interrupt level
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        irq <= 1'b0;
    else
        irq <= |(status_reg & mask_reg);
end

endmodule
`default_nettype wire
